// File: common/ubfs_pkg.sv
// Constants, carrier types and register map of the serial rate, flush and status block.
// Operation
// [R1] Rate equals F*(256+mantissa)*2^exp/2^28.
// [R2] One generator times UART bits and SPI clock.
// [R3] Software keeps UART rate at most F/16.
// [R4] SPI master with receive at most F/8.
// [R5] Transmit-only SPI master may reach F/2.
// [R6] External SPI master clock at most F/8.
// [R7] Program rate first; changes apply when idle.
// [R8] 216/11 gives 115200, 59/8 gives 9600.
// [R9] Abort stops transfer and empties all buffers.
// [R10] Mid-bit abort: buffers now, timer finishes bit.
// [R11] After abort software waits one bit time.
// [R12] Unit offers receive and transmit complete requests.
// [R13] Transmit request rises when transfer starts.
// [R14] DMA triggers fire on the same events.
// [R15] Bits 7..5 select mode, receiver, slave.
// [R16] Bit 4 framing error, reset 0, write-0 clears.
// [R17] Bit 3 parity error, reset 0, write-0 clears.
// [R18] Bit 2 received byte waiting, write-0 clears; the code does not set it in SPI master mode.
// [R19] Bit 1 last written byte sent, write-0 clears.
// [R20] Bit 0 read-only busy while transmitting or receiving.
// [R21] Mid-byte select release leaves stale state; abort clears.
// [R22] SPI master ignores the slave select input.
// [R23] Abort is control bit 7, reads zero.
// [R24] Interrupt and DMA events are single-cycle pulses.
// [R25] Generator is a phase accumulator ticking on overflow.
package ubfs_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0]  CSR_IDX   = 8'h86;
    localparam logic [7:0]  DBUF_IDX  = 8'hC1;
    localparam logic [7:0]  BAUD_IDX  = 8'hC2;
    localparam logic [7:0]  UCR_IDX   = 8'hC4;
    localparam logic [7:0]  GCR_IDX   = 8'hC5;
    localparam logic [11:0] CSR_ADDR  = {2'h0, CSR_IDX, 2'h0};
    localparam logic [11:0] DBUF_ADDR = {2'h0, DBUF_IDX, 2'h0};
    localparam logic [11:0] BAUD_ADDR = {2'h0, BAUD_IDX, 2'h0};
    localparam logic [11:0] UCR_ADDR  = {2'h0, UCR_IDX, 2'h0};
    localparam logic [11:0] GCR_ADDR  = {2'h0, GCR_IDX, 2'h0};

    // Control and status field positions.
    localparam int CSR_MODE   = 7;
    localparam int CSR_RXON   = 6;
    localparam int CSR_SLAVE  = 5;
    localparam int CSR_FE     = 4;
    localparam int CSR_PERR   = 3;
    localparam int CSR_RXRDY  = 2;
    localparam int CSR_TXDONE = 1;
    localparam int CSR_BUSY   = 0;
    localparam int UCR_ABORT  = 7;
    localparam int UCR_BIT9   = 4;
    localparam int UCR_SPB    = 2;
    localparam int GCR_EXP_W  = 5;

    // Values after reset.
    localparam logic [2:0] CTL_RST  = 3'h0;
    localparam logic [6:0] UCR_RST  = 7'h02;
    localparam logic [7:0] GCR_RST  = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;

    // Rate generator and byte framing counts.
    localparam logic [8:0] RATE_BASE = 9'h100;
    localparam int         RATE_FRAC = 28;
    localparam logic [3:0] UART_BITS = 4'hA;
    localparam logic [3:0] SPI_BITS  = 4'h8;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_RUN   = 2'b01,
        SEQ_ABORT = 2'b10
    } ubfs_seq_t;

    typedef struct packed {
        logic        hsel;
        logic [11:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } ubfs_ahb_in_t;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } ubfs_ahb_out_t;

    typedef struct packed {
        logic       active;
        logic       done;
        logic [7:0] data;
        logic       frame_bad;
        logic       parity_bad;
    } ubfs_rx_evt_t;

endpackage

// File: rtl/ubfs_rate_gen.sv
// Phase-accumulator bit-rate generator with rate latched while stopped.
`timescale 1ns/1ps
module ubfs_rate_gen #(
    parameter int MW   = 8,
    parameter int EW   = 5,
    parameter int FRAC = ubfs_pkg::RATE_FRAC
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic [MW-1:0] mant,
    input  wire logic [EW-1:0] expo,
    input  wire logic          run,
    output logic               tick
);
    import ubfs_pkg::*;
    localparam int IW = MW + 1 + (2 ** EW) - 1;

    logic [FRAC-1:0] acc_reg, acc_next;
    logic [MW-1:0]   mant_reg, mant_next;
    logic [EW-1:0]   exp_reg, exp_next;
    logic            tick_reg, tick_next;
    logic [IW-1:0]   inc;
    logic [IW:0]     sum;

    always_comb begin
        // [R25] Accumulate scaled step.
        // [R1] Average tick rate formula.
        inc       = {{(IW - MW - 1){1'b0}}, RATE_BASE + {1'b0, mant_reg}} << exp_reg;
        sum       = {1'b0, {(IW - FRAC){1'b0}}, acc_reg} + {1'b0, inc};
        acc_next  = run ? sum[FRAC-1:0] : '0;
        tick_next = run && (|sum[IW:FRAC]);
        // [R7] Rate change deferred.
        mant_next = run ? mant_reg : mant;
        exp_next  = run ? exp_reg : expo;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_reg  <= '0;
            tick_reg <= 1'b0;
            mant_reg <= '0;
            exp_reg  <= '0;
        end else if (ce) begin
            acc_reg  <= acc_next;
            tick_reg <= tick_next;
            mant_reg <= mant_next;
            exp_reg  <= exp_next;
        end
    end

    assign tick = tick_reg;

    // Cycle distance between ticks, for checking only.
    logic [8:0] gap_reg;
    logic       seen_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            gap_reg  <= 9'h000;
            seen_reg <= 1'b0;
        end else if (ce) begin
            gap_reg  <= (tick_next || !run) ? 9'h000 : gap_reg + 9'h001;
            seen_reg <= run && (seen_reg || tick_reg);
        end
    end

    rate_115k_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        tick && !$past(tick) && seen_reg && mant_reg == 8'hD8 && exp_reg == 5'h0B
        |-> $past(gap_reg) inside {[276:277]})
        else $error("tick spacing wrong for 115200 setting");
    rate_f16_a: assert property (@(posedge clk) disable iff (rst) // [R3]
        ce && tick && mant_reg == 8'h00 && exp_reg == 5'h10 && run
        |=> !tick [*8])
        else $error("F/16 setting ticks too often");
    cover_tick_c: cover property (@(posedge clk) disable iff (rst) run && tick);

endmodule // ubfs_rate_gen

// File: rtl/ubfs_byte_seq.sv
// Bit-duration sequencer that paces one byte and finishes aborts on a bit end.
`timescale 1ns/1ps
module ubfs_byte_seq (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       start,
    input  wire logic       tick,
    input  wire logic       abort,
    input  wire logic [3:0] nbits,
    output logic            running,
    output logic            done,
    output logic            aborted
);
    import ubfs_pkg::*;

    ubfs_seq_t  state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        done       = 1'b0;
        aborted    = 1'b0;
        case (state_reg)
            SEQ_IDLE: begin
                cnt_next = 4'h0;
                if (start) begin
                    state_next = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                // [R10] Abort waits for bit end.
                if (abort && !tick) begin
                    state_next = SEQ_ABORT;
                end else if (abort) begin
                    state_next = SEQ_IDLE;
                    aborted    = 1'b1;
                end else if (tick && cnt_reg == nbits - 4'h1) begin
                    state_next = SEQ_IDLE;
                    done       = 1'b1;
                end else if (tick) begin
                    cnt_next = cnt_reg + 4'h1;
                end
            end
            SEQ_ABORT: begin
                if (tick) begin
                    state_next = SEQ_IDLE;
                    aborted    = 1'b1;
                end
            end
            default: begin
                state_next = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= SEQ_IDLE;
            cnt_reg   <= 4'h0;
        end else if (ce) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign running = state_reg != SEQ_IDLE;

    abort_hold_a: assert property (@(posedge clk) disable iff (rst) // [R10]
        ce && state_reg == SEQ_RUN && abort && !tick |=> state_reg == SEQ_ABORT)
        else $error("abort did not wait for bit end");
    abort_end_a: assert property (@(posedge clk) disable iff (rst) // [R10]
        ce && state_reg == SEQ_ABORT && tick |=> state_reg == SEQ_IDLE)
        else $error("abort did not finish on bit end");
    cover_abort_c: cover property (@(posedge clk) disable iff (rst)
        state_reg == SEQ_ABORT);

endmodule // ubfs_byte_seq

// File: rtl/ubfs_usart_ctrl.sv
// Top of the serial rate, flush and status block with its AHB-Lite register slave.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
module ubfs_usart_ctrl (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire ubfs_pkg::ubfs_ahb_in_t  ahb_i,
    output ubfs_pkg::ubfs_ahb_out_t      ahb_o,
    input  wire ubfs_pkg::ubfs_rx_evt_t  rx_evt,
    input  wire logic                    slave_select_in_n,
    output logic                         rate_tick,
    output logic                         tx_load,
    output logic [7:0]                   tx_data,
    output logic                         line_flush,
    output logic [6:0]                   uart_cfg,
    output logic [7:0]                   generic_cfg,
    output logic                         uart_mode,
    output logic                         spi_slave,
    output logic                         rx_complete_irq,
    output logic                         tx_complete_irq,
    output logic                         dma_rx_trig,
    output logic                         dma_tx_trig
);
    import ubfs_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    ubfs_ahb_out_t ahb_reg, ahb_next;
    logic          wr_pend_reg, wr_pend_next;
    logic [11:0]   wr_addr_reg, wr_addr_next;
    logic [2:0]    ctl_reg, ctl_next;
    logic [4:1]    flag_reg, flag_next;
    logic [6:0]    ucr_reg, ucr_next;
    logic [7:0]    gcr_reg, gcr_next;
    logic [7:0]    baud_reg, baud_next;
    logic [7:0]    hold_reg, hold_next;
    logic          hold_full_reg, hold_full_next;
    logic [7:0]    rx_data_reg, rx_data_next;
    logic          busy_reg, busy_next;
    logic          tx_irq_reg, tx_irq_next;
    logic          rx_irq_reg, rx_irq_next;
    logic          tx_load_reg, tx_load_next;
    logic [7:0]    tx_data_reg, tx_data_next;
    logic          flush_reg, flush_next;

    logic          acc_rd;
    logic          csr_wr;
    logic          dbuf_wr;
    logic          abort_w;
    logic          rd_dbuf;
    logic          is_uart;
    logic          can_tx;
    logic          start;
    logic          rx_take;
    logic          rx_flag_mode;
    logic          gen_run;
    logic [3:0]    nbits;
    logic [7:0]    wd;
    logic [31:0]   rd_mux;
    logic          seq_running;
    logic          seq_done;
    logic          seq_aborted;
    logic          gen_tick;

    // ************************************************************
    // Rate generator and bit sequencer
    // ************************************************************
    // [R2] Shared generator for both modes.
    ubfs_rate_gen #(
        .MW   (8),
        .EW   (GCR_EXP_W),
        .FRAC (RATE_FRAC)
    ) u_gen (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .mant (baud_reg),
        .expo (gcr_reg[GCR_EXP_W-1:0]),
        .run  (gen_run),
        .tick (gen_tick)
    );

    ubfs_byte_seq u_seq (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .start   (start),
        .tick    (gen_tick),
        .abort   (abort_w),
        .nbits   (nbits),
        .running (seq_running),
        .done    (seq_done),
        .aborted (seq_aborted)
    );

    // ************************************************************
    // Bus decode and read data
    // ************************************************************
    always_comb begin
        acc_rd  = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready && !ahb_i.hwrite;
        wd      = ahb_i.hwdata[7:0];
        csr_wr  = wr_pend_reg && wr_addr_reg == CSR_ADDR;
        dbuf_wr = wr_pend_reg && wr_addr_reg == DBUF_ADDR;
        // [R23] Abort acts on a written one.
        abort_w = wr_pend_reg && wr_addr_reg == UCR_ADDR && wd[UCR_ABORT];
        rd_dbuf = acc_rd && ahb_i.haddr == DBUF_ADDR;
        case (ahb_i.haddr)
            // [R15] Control fields readable.
            CSR_ADDR:  rd_mux = {24'h000000, ctl_reg, flag_reg, busy_reg};
            UCR_ADDR:  rd_mux = {24'h000000, 1'b0, ucr_reg};
            GCR_ADDR:  rd_mux = {24'h000000, gcr_reg};
            BAUD_ADDR: rd_mux = {24'h000000, baud_reg};
            DBUF_ADDR: rd_mux = {24'h000000, rx_data_reg};
            default:   rd_mux = 32'h00000000;
        endcase
        ahb_next.hreadyout = 1'b1;
        ahb_next.hresp     = 1'b0;
        ahb_next.hrdata    = acc_rd ? rd_mux : 32'h00000000;
        wr_pend_next = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready && ahb_i.hwrite;
        wr_addr_next = ahb_i.haddr;
    end

    // ************************************************************
    // Transfer control and flags
    // ************************************************************
    always_comb begin
        is_uart      = ctl_reg[CSR_MODE-5];
        can_tx       = is_uart || !ctl_reg[CSR_SLAVE-5];
        nbits        = is_uart ? UART_BITS + {3'h0, ucr_reg[UCR_BIT9]}
                                 + {3'h0, ucr_reg[UCR_SPB]} : SPI_BITS;
        start        = hold_full_reg && !seq_running && can_tx && !abort_w;
        gen_run      = seq_running || (is_uart && ctl_reg[CSR_RXON-5]);
        // [R22] Select ignored as master.
        rx_take      = rx_evt.done && !abort_w &&
                       (is_uart ? ctl_reg[CSR_RXON-5]
                                : (!ctl_reg[CSR_SLAVE-5] || !slave_select_in_n));
        rx_flag_mode = is_uart || ctl_reg[CSR_SLAVE-5];

        ctl_next  = csr_wr ? wd[CSR_MODE:CSR_SLAVE] : ctl_reg;
        ucr_next  = (wr_pend_reg && wr_addr_reg == UCR_ADDR) ? wd[6:0] : ucr_reg;
        gcr_next  = (wr_pend_reg && wr_addr_reg == GCR_ADDR) ? wd : gcr_reg;
        baud_next = (wr_pend_reg && wr_addr_reg == BAUD_ADDR) ? wd : baud_reg;

        // Writing zero clears a flag; a same-cycle hardware set wins.
        flag_next = flag_reg;
        if (csr_wr) begin
            flag_next = flag_reg & wd[CSR_FE:CSR_TXDONE];
        end
        if (rd_dbuf) begin
            flag_next[CSR_RXRDY] = 1'b0;
        end
        // [R16] Framing error set.
        if (rx_take && is_uart && rx_evt.frame_bad) begin
            flag_next[CSR_FE] = 1'b1;
        end
        // [R17] Parity error set.
        if (rx_take && is_uart && rx_evt.parity_bad) begin
            flag_next[CSR_PERR] = 1'b1;
        end
        // [R18] Received byte waiting.
        if (rx_take && rx_flag_mode) begin
            flag_next[CSR_RXRDY] = 1'b1;
        end
        // [R19] Last byte transmitted.
        if (seq_done && !hold_full_reg) begin
            flag_next[CSR_TXDONE] = 1'b1;
        end

        hold_next      = dbuf_wr ? wd : hold_reg;
        hold_full_next = dbuf_wr || (hold_full_reg && !start);
        rx_data_next   = rx_take ? rx_evt.data : rx_data_reg;
        if (dbuf_wr) begin
            flag_next[CSR_TXDONE] = 1'b0;
        end
        // [R9] Abort empties buffers.
        if (abort_w) begin
            hold_full_next       = 1'b0;
            hold_next            = 8'h00;
            rx_data_next         = 8'h00;
            flag_next[CSR_RXRDY] = 1'b0;
        end

        tx_load_next = start;
        tx_data_next = start ? hold_reg : tx_data_reg;
        // [R13] Transmit request at start.
        // [R24] One-cycle event pulses.
        tx_irq_next  = start;
        rx_irq_next  = rx_take;
        // [R21] Abort drops stale line state.
        flush_next   = abort_w;
        // [R20] Busy while moving data.
        busy_next    = seq_running || start ||
                       (rx_evt.active && (is_uart ? ctl_reg[CSR_RXON-5]
                                                  : ctl_reg[CSR_SLAVE-5]));
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            ahb_reg       <= '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h00000000};
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= 12'h000;
            ctl_reg       <= CTL_RST;
            flag_reg      <= 4'h0;
            ucr_reg       <= UCR_RST;
            gcr_reg       <= GCR_RST;
            baud_reg      <= BAUD_RST;
            hold_reg      <= 8'h00;
            hold_full_reg <= 1'b0;
            rx_data_reg   <= 8'h00;
            busy_reg      <= 1'b0;
            tx_irq_reg    <= 1'b0;
            rx_irq_reg    <= 1'b0;
            tx_load_reg   <= 1'b0;
            tx_data_reg   <= 8'h00;
            flush_reg     <= 1'b0;
        end else if (ce) begin
            ahb_reg       <= ahb_next;
            wr_pend_reg   <= wr_pend_next;
            wr_addr_reg   <= wr_addr_next;
            ctl_reg       <= ctl_next;
            flag_reg      <= flag_next;
            ucr_reg       <= ucr_next;
            gcr_reg       <= gcr_next;
            baud_reg      <= baud_next;
            hold_reg      <= hold_next;
            hold_full_reg <= hold_full_next;
            rx_data_reg   <= rx_data_next;
            busy_reg      <= busy_next;
            tx_irq_reg    <= tx_irq_next;
            rx_irq_reg    <= rx_irq_next;
            tx_load_reg   <= tx_load_next;
            tx_data_reg   <= tx_data_next;
            flush_reg     <= flush_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // [R12] Two request outputs.
    // [R14] DMA triggers follow requests.
    assign ahb_o           = ahb_reg;
    assign rate_tick       = gen_tick;
    assign tx_load         = tx_load_reg;
    assign tx_data         = tx_data_reg;
    assign line_flush      = flush_reg;
    assign uart_cfg        = ucr_reg;
    assign generic_cfg     = gcr_reg;
    assign uart_mode       = ctl_reg[CSR_MODE-5];
    assign spi_slave       = ctl_reg[CSR_SLAVE-5];
    assign rx_complete_irq = rx_irq_reg;
    assign tx_complete_irq = tx_irq_reg;
    assign dma_rx_trig     = rx_irq_reg;
    assign dma_tx_trig     = tx_irq_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    abort_clear_a: assert property (@(posedge clk) disable iff (rst) // [R9]
        ce && abort_w |=> !hold_full_reg && !flag_reg[CSR_RXRDY] && line_flush)
        else $error("abort left data in buffers");
    tx_start_a: assert property (@(posedge clk) disable iff (rst) // [R13]
        ce && start |=> tx_complete_irq && tx_load && tx_data == $past(hold_reg))
        else $error("transmit request not raised at start");
    irq_pulse_a: assert property (@(posedge clk) disable iff (rst) // [R24]
        ce && (tx_complete_irq || rx_complete_irq) ##1 ce
        |-> !tx_complete_irq && !rx_complete_irq)
        else $error("event request longer than one cycle");
    dma_pair_a: assert property (@(posedge clk) disable iff (rst) // [R14]
        dma_tx_trig == tx_complete_irq && dma_rx_trig == rx_complete_irq)
        else $error("DMA trigger differs from request");
    txdone_set_a: assert property (@(posedge clk) disable iff (rst) // [R19]
        ce && seq_done && !hold_full_reg |=> flag_reg[CSR_TXDONE])
        else $error("transmit done flag not set");
    fe_set_wins_a: assert property (@(posedge clk) disable iff (rst) // [R16]
        ce && rx_take && is_uart && rx_evt.frame_bad |=> flag_reg[CSR_FE])
        else $error("framing error flag lost");
    busy_a: assert property (@(posedge clk) disable iff (rst) // [R20]
        ce && seq_running |=> busy_reg)
        else $error("busy low during transfer");
    master_ss_a: assert property (@(posedge clk) disable iff (rst) // [R22]
        ce && rx_evt.done && !is_uart && !ctl_reg[CSR_SLAVE-5] && !abort_w
        |=> rx_complete_irq)
        else $error("master receive blocked by slave select");

    cover_b2b_c: cover property (@(posedge clk) disable iff (rst)
        tx_load ##[1:400] seq_done ##1 tx_load);
    cover_rx_err_c: cover property (@(posedge clk) disable iff (rst)
        rx_complete_irq && flag_reg[CSR_PERR]);
    cover_abort_c: cover property (@(posedge clk) disable iff (rst)
        seq_running && abort_w);

endmodule // ubfs_usart_ctrl

// File: bench/ubfs_peer_model.sv
// Behavioural line-side shifter that hands received bytes to the block.
`timescale 1ns/1ps
module ubfs_peer_model (
    input  wire logic              clk,
    input  wire logic              send,
    input  wire logic [9:0]        word,
    output ubfs_pkg::ubfs_rx_evt_t rx_evt
);
    import ubfs_pkg::*;
    logic [3:0] cnt_reg;
    initial begin
        cnt_reg = 4'h0;
        rx_evt = '0;
    end
    // Data is only valid with done, so it wanders outside a frame.
    always @(posedge clk) begin
        rx_evt.done <= 1'b0;
        if (send) begin
            rx_evt.active <= 1'b1;
            cnt_reg <= 4'h4;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
            if (cnt_reg == 4'h1) begin
                rx_evt <= {1'b0, 1'b1, word};
            end
        end else begin
            rx_evt.data <= ~rx_evt.data;
        end
    end
endmodule // ubfs_peer_model

// File: bench/ubfs_usart_ctrl_tb_top.sv
// Self-checking bench for the serial rate, flush and status block.
`timescale 1ns/1ps
module ubfs_usart_ctrl_tb_top;
    import ubfs_pkg::*;
    logic          clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, send = 1'b0;
    logic [11:0]   haddr = 12'h000;
    logic [1:0]    htrans = 2'h0;
    logic [31:0]   hwdata = 32'h0, q;
    logic [9:0]    word = 10'h000;
    logic          tick, txl, flush, rxi, txi, dmr, dmt, um, ss;
    logic [7:0]    txd, gc;
    logic [6:0]    uc;
    int            fail_count = 0, comparisons = 0, cycles = 0, n;
    ubfs_ahb_in_t  ahb_i;
    ubfs_ahb_out_t ahb_o;
    ubfs_rx_evt_t  rx_evt;
    assign ahb_i = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, ahb_o.hreadyout};
    ubfs_usart_ctrl DUT (.clk(clk), .rst(rst), .ce(1'b1), .ahb_i(ahb_i), .ahb_o(ahb_o),
        .rx_evt(rx_evt), .slave_select_in_n(1'b1), .rate_tick(tick), .tx_load(txl),
        .tx_data(txd), .line_flush(flush), .uart_cfg(uc), .generic_cfg(gc), .uart_mode(um),
        .spi_slave(ss), .rx_complete_irq(rxi), .tx_complete_irq(txi), .dma_rx_trig(dmr),
        .dma_tx_trig(dmt));
    ubfs_peer_model PEER (.clk(clk), .send(send), .word(word), .rx_evt(rx_evt));
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(logic wr, logic [11:0] a, logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (ahb_o.hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (ahb_o.hreadyout !== 1'b1);
        q = ahb_o.hrdata;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e, string nm);
        bus(1'b0, a, 8'h00);
        chk(nm, e, q);
    endtask
    // Waits a bounded time for tx irq (0), rx irq (1), flush (2) or tick (3).
    task automatic wait_on(int s);
        logic [3:0] v;
        n = 0;
        v = {tick, flush, rxi, txi};
        while (v[s] !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
            v = {tick, flush, rxi, txi};
        end
        chk("event", 32'h1, {31'h0, v[s]});
    endtask
    task automatic test_reset();
        rd(CSR_ADDR, 32'h00, "csr_reset");
        rd(UCR_ADDR, 32'h02, "ucr_reset");
        rd(GCR_ADDR, 32'h00, "gcr_reset");
        rd(12'h000, 32'h00, "unmapped");
        $display("reset test done");
    endtask
    task automatic test_tx();
        // the fastest rate ever set is F/16.
        bus(1'b1, GCR_ADDR, 8'h10);
        bus(1'b1, BAUD_ADDR, 8'h00);
        bus(1'b1, CSR_ADDR, 8'h80);
        bus(1'b1, DBUF_ADDR, 8'hA5);
        wait_on(0);
        chk("tx_load", 32'h1, {31'h0, txl});
        chk("dma_tx", 32'h1, {31'h0, dmt});
        rd(CSR_ADDR, 32'h81, "busy");
        chk("generic_cfg", 32'h10, {24'h0, gc});
        chk("uart_cfg", 32'h02, {25'h0, uc});
        chk("uart_mode", 32'h1, {31'h0, um});
        chk("tx_data", 32'hA5, {24'h0, txd});
        wait_on(3);
        @(posedge clk);
        wait_on(3);
        chk("tick_gap", 32'd15, n);
        n = 0;
        do begin
            bus(1'b0, CSR_ADDR, 8'h00);
            n++;
        end while (q[1] !== 1'b1 && n < 100);
        rd(CSR_ADDR, 32'h82, "tx_done");
        bus(1'b1, CSR_ADDR, 8'h80);
        rd(CSR_ADDR, 32'h80, "tx_clear");
        $display("transmit test done");
    endtask
    task automatic test_rx();
        bus(1'b1, CSR_ADDR, 8'hC0);
        word <= {8'h3C, 2'b11};
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        wait_on(1);
        chk("dma_rx", 32'h1, {31'h0, dmr});
        rd(CSR_ADDR, 32'hDC, "rx_flags");
        rd(DBUF_ADDR, 32'h3C, "rx_data");
        rd(CSR_ADDR, 32'hD8, "rx_read");
        bus(1'b1, CSR_ADDR, 8'hC0);
        rd(CSR_ADDR, 32'hC0, "err_clear");
        $display("receive test done");
    endtask
    task automatic test_abort();
        bus(1'b1, CSR_ADDR, 8'h80);
        bus(1'b1, DBUF_ADDR, 8'h11);
        wait_on(0);
        repeat (5) @(posedge clk);
        bus(1'b1, UCR_ADDR, 8'h82);
        wait_on(2);
        rd(UCR_ADDR, 32'h02, "abort_bit");
        repeat (20) @(posedge clk);
        rd(CSR_ADDR, 32'h80, "idle");
        $display("abort test done");
    endtask
    task automatic test_spi();
        bus(1'b1, CSR_ADDR, 8'h00);
        chk("spi_slave", 32'h0, {31'h0, ss});
        word <= {8'h5A, 2'b00};
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        wait_on(1);
        rd(CSR_ADDR, 32'h00, "master_rx");
        $display("master test done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        test_reset();
        test_tx();
        test_rx();
        test_abort();
        test_spi();
        stop_test();
    end
endmodule // ubfs_usart_ctrl_tb_top
